// >>> pkg/ssc_pkg.sv
// Shared constants and types for the safeguard state controller.
// Assumes a single 125 MHz system clock; all timing is derived from it.
`default_nettype none
package ssc_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ  = 125;
  localparam int SCAN_MS  = 40;
  // One scan period counted in system clock cycles.
  localparam int SCAN_CYC = SCAN_MS * CLK_MHZ * 1000;
  localparam logic [4:0] SCAN_MIN   = 5'h02;
  localparam logic [4:0] SCAN_MAX   = 5'h11;
  // Scan counts from this value up show a zero second digit.
  localparam logic [4:0] SCAN_ZDIG  = 5'h0a;
  // The fault indicator toggles after this many scans.
  localparam logic [3:0] FLASH_SCANS = 4'h5;
  // ==========================================================
  // Output levels and display digits
  localparam logic [1:0] PAIR_OFF     = 2'h0;
  localparam logic [1:0] PAIR_ON      = 2'h3;
  localparam logic [3:0] DIG_ILK_HI   = 4'h0;
  localparam logic [3:0] DIG_ILK_LO   = 4'h1;
  localparam logic [3:0] DIG_FAULT_HI = 4'h5;
  localparam logic [3:0] DIG_UNION    = 4'ha;
  localparam logic [3:0] DIG_ZERO     = 4'h0;
  localparam logic [3:0] DIG_BLANK    = 4'hf;
  // ==========================================================
  // Modes and states
  typedef enum logic [1:0] {
    SSC_AUTO        = 2'h0,
    SSC_START_ILK   = 2'h1,
    SSC_RESTART_ILK = 2'h2
  } ssc_mode_t;
  typedef enum logic {
    SSC_AUX_FOLLOW = 1'h0,
    SSC_AUX_ALARM  = 1'h1
  } ssc_aux_t;
  typedef enum logic [4:0] {
    SSC_INIT  = 5'h01,
    SSC_RUN   = 5'h02,
    SSC_STOP  = 5'h04,
    SSC_ILK   = 5'h08,
    SSC_FAULT = 5'h10
  } ssc_state_t;
endpackage
`default_nettype wire

// >>> pkg/ssc_link_if.sv
// Signals passed between the controller and its two helper blocks.
// Assumes all three run on the same clock and reset.
`timescale 1ns/1ns
`default_nettype none
interface ssc_link_if;
  logic       start_pulse;
  logic       arm;
  logic [4:0] scans;
  logic       expired;
  logic       scan_tick;
  modport det (output start_pulse);
  modport tmr (input arm, input scans, output expired, output scan_tick);
  modport ctl (input start_pulse, output arm, output scans,
               input expired, input scan_tick);
endinterface
`default_nettype wire

// >>> rtl/ssc_start_detect.sv
// Start button press-and-release detector.
// Assumes the button input is already synchronous and debounced.
`timescale 1ns/1ns
`default_nettype none
module ssc_start_detect (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic start_btn_in,
  ssc_link_if.det   lnk
);
  import ssc_pkg::*;

  logic armed_q, armed_d;
  logic pressed_q, pressed_d;
  logic pulse_q, pulse_d;

  // ==========================================================
  // Press tracking
  // A press counts only once the button was first seen released, so a
  // button held through reset never yields a start.
  always_comb
  begin
    armed_d   = armed_q | ~start_btn_in;
    pressed_d = pressed_q;
    pulse_d   = 1'b0;
    if (start_btn_in && armed_q)
      pressed_d = 1'b1;
    if (!start_btn_in && pressed_q)
    begin
      pressed_d = 1'b0;
      pulse_d   = 1'b1;
    end
  end

  // Registers only.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      armed_q   <= 1'b0;
      pressed_q <= 1'b0;
      pulse_q   <= 1'b0;
    end
    else
    begin
      armed_q   <= armed_d;
      pressed_q <= pressed_d;
      pulse_q   <= pulse_d;
    end
  end

  assign lnk.start_pulse = pulse_q;

  // ==========================================================
  // Checks
  // pulse needs press then release
  release_only_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pulse_q |-> $past(!start_btn_in) && $past(pressed_q))
    else $error("start pulse without a completed press");
endmodule
`default_nettype wire

// >>> rtl/ssc_resp_timer.sv
// Response time counter and free-running scan tick.
// Assumes scans is already clamped to the legal range by the caller.
`timescale 1ns/1ns
`default_nettype none
module ssc_resp_timer #(
  parameter int SCAN_CYC = ssc_pkg::SCAN_CYC
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  ssc_link_if.tmr   lnk
);
  import ssc_pkg::*;

  logic [31:0] resp_q, resp_d;
  logic [31:0] tick_q, tick_d;
  logic        exp_q, exp_d;
  logic        stb_q, stb_d;
  logic [31:0] limit;

  assign limit = 32'(lnk.scans) * 32'(SCAN_CYC);

  // ==========================================================
  // Counters
  // The response count restarts whenever the intrusion drops, so only an
  // unbroken intrusion for the whole response time turns the outputs off.
  always_comb
  begin
    resp_d = 32'h0;
    exp_d  = 1'b0;
    if (lnk.arm)
    begin
      if (resp_q >= limit - 32'h1)
        exp_d = 1'b1;
      else
        resp_d = resp_q + 32'h1;
    end
    stb_d  = (tick_q == 32'(SCAN_CYC - 1));
    tick_d = stb_d ? 32'h0 : tick_q + 32'h1;
  end

  // Registers only.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      resp_q <= 32'h0;
      tick_q <= 32'h0;
      exp_q  <= 1'b0;
      stb_q  <= 1'b0;
    end
    else
    begin
      resp_q <= resp_d;
      tick_q <= tick_d;
      exp_q  <= exp_d;
      stb_q  <= stb_d;
    end
  end

  assign lnk.expired   = exp_q;
  assign lnk.scan_tick = stb_q;
endmodule
`default_nettype wire

// >>> rtl/ssc_ctrl.sv
// Operating-state controller: run, stop, interlock and fault.
// Assumes all inputs are synchronous to clk_in and the self-test engine
// reports done and fail as levels.
//
// Contract
// - Run drives both safety outputs on, green lit, start button ignored.
// - Stop holds safety outputs off, red lit, auxiliary per its mode.
// - Interlock: outputs off, red and yellow lit, code 01, needs clear and start.
// - Fault: outputs off, red lit, yellow flashing, code 5X.
// - Auxiliary on in fault only in alarm mode, else off.
// - Fault holds until the fault is corrected; start cannot clear it.
// - Run shows the zone and response status code.
// - Automatic start powers up off, self-tests, then runs if zone clear.
// - Intrusion in run stops within response time, stays while intrusion persists.
// - Automatic mode returns from stop to run when zone clears.
// - Start interlock powers up to interlock, or stop then interlock.
// - Safety outputs off during tests, initialization and entry to interlock.
// - Interlock to run only after a full start press and release.
// - Start interlock mode, after running, returns stop to run by itself.
// - Restart mode powers up to stop while intruded, interlock when clear.
// - Restart mode goes stop to interlock on clear, needs fresh start.
// - Auxiliary follows safety outputs or marks fault, per its mode.
// - Response time is scan count 2 to 17 times 40 ms.
`timescale 1ns/1ns
`default_nettype none
module ssc_ctrl #(
  parameter int SCAN_CYC = ssc_pkg::SCAN_CYC
) (
  input  wire logic               clk_in,
  input  wire logic               nrst_in,
  input  wire logic               safety_zone_in,
  input  wire logic               warn_zone_in,
  input  wire logic               selftest_done_in,
  input  wire logic               selftest_fail_in,
  input  wire logic [3:0]         fault_code_in,
  input  wire logic               start_btn_in,
  input  wire ssc_pkg::ssc_mode_t start_mode_in,
  input  wire ssc_pkg::ssc_aux_t  aux_mode_in,
  input  wire logic [4:0]         scan_count_in,
  input  wire logic [1:0]         zone_set_in,
  output logic [1:0]              safety_output_pair_out,
  output logic                    run_led_out,
  output logic                    stop_led_out,
  output logic                    ilk_led_out,
  output logic                    aux_out,
  output logic                    warn_out,
  output logic [3:0]              diag_hi_out,
  output logic [3:0]              diag_lo_out
);
  import ssc_pkg::*;

  ssc_link_if lnk ();

  ssc_state_t  state_q, state_d;
  logic        ran_q, ran_d;
  logic        flash_q, flash_d;
  logic [3:0]  fcnt_q, fcnt_d;
  logic [1:0]  pair_q, pair_d;
  logic        run_q, run_d;
  logic        stop_q, stop_d;
  logic        ilk_q, ilk_d;
  logic        aux_q, aux_d;
  logic        warn_q, warn_d;
  logic [3:0]  dhi_q, dhi_d;
  logic [3:0]  dlo_q, dlo_d;
  logic [4:0]  scans;

  // ==========================================================
  // Helpers
  // Out-of-range scan settings are clamped rather than rejected, so a bad
  // setting can never shorten the response below two scans.
  function automatic logic [4:0] clamp_scans(input logic [4:0] s);
    if (s < SCAN_MIN)
      return SCAN_MIN;
    if (s > SCAN_MAX)
      return SCAN_MAX;
    return s;
  endfunction

  // First status digit from the active zone set.
  function automatic logic [3:0] zone_digit(input logic [1:0] z);
    case (z)
      2'h1:    return 4'h1;
      2'h2:    return 4'h2;
      2'h3:    return DIG_UNION;
      default: return DIG_BLANK;
    endcase
  endfunction

  // Second status digit from the scan count; long times show zero.
  function automatic logic [3:0] scan_digit(input logic [4:0] s);
    if (s >= SCAN_ZDIG)
      return DIG_ZERO;
    return s[3:0];
  endfunction

  assign scans     = clamp_scans(scan_count_in);
  assign lnk.scans = scans;

  assign lnk.arm = (state_q == SSC_RUN) && safety_zone_in;

  // ==========================================================
  // Helper blocks
  ssc_start_detect u_start (
    .clk_in       (clk_in),
    .nrst_in      (nrst_in),
    .start_btn_in (start_btn_in),
    .lnk          (lnk.det)
  );

  ssc_resp_timer #(
    .SCAN_CYC (SCAN_CYC)
  ) u_timer (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .lnk     (lnk.tmr)
  );

  // ==========================================================
  // State machine next state
  // A fault outranks every other event. Leaving fault goes back through
  // initialization so the self-tests are judged afresh.
  always_comb
  begin
    state_d = state_q;
    ran_d   = ran_q;
    case (state_q)
      SSC_INIT:
      begin
        ran_d = 1'b0;
        if (selftest_fail_in)
          state_d = SSC_FAULT;
        else if (selftest_done_in)
        begin
          if (safety_zone_in)
            state_d = SSC_STOP;
          else if (start_mode_in == SSC_AUTO)
            state_d = SSC_RUN;
          else
            state_d = SSC_ILK;
        end
      end
      SSC_RUN:
      begin
        if (selftest_fail_in)
          state_d = SSC_FAULT;
        else if (lnk.expired)
          state_d = SSC_STOP;
      end
      SSC_STOP:
      begin
        if (selftest_fail_in)
          state_d = SSC_FAULT;
        else if (!safety_zone_in)
        begin
          if (start_mode_in == SSC_AUTO)
            state_d = SSC_RUN;
          else if (start_mode_in == SSC_START_ILK && ran_q)
            state_d = SSC_RUN;
          else
            state_d = SSC_ILK;
        end
      end
      SSC_ILK:
      begin
        if (selftest_fail_in)
          state_d = SSC_FAULT;
        else if (lnk.start_pulse && !safety_zone_in)
          state_d = SSC_RUN;
      end
      SSC_FAULT:
      begin
        if (!selftest_fail_in)
          state_d = SSC_INIT;
      end
      default:
        state_d = SSC_FAULT;
    endcase
    if (state_d == SSC_RUN)
      ran_d = 1'b1;
  end

  // Registers only.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_q <= SSC_INIT;
      ran_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      ran_q   <= ran_d;
    end
  end

  // ==========================================================
  // Outputs, computed from the next state so the pins line up with state_q
  always_comb
  begin
    fcnt_d  = fcnt_q;
    flash_d = flash_q;
    if (lnk.scan_tick)
    begin
      if (fcnt_q >= FLASH_SCANS - 4'h1)
      begin
        fcnt_d  = 4'h0;
        flash_d = ~flash_q;
      end
      else
        fcnt_d = fcnt_q + 4'h1;
    end
    warn_d = warn_zone_in;
    pair_d = PAIR_OFF;
    run_d  = 1'b0;
    stop_d = 1'b1;
    ilk_d  = 1'b0;
    dhi_d  = DIG_BLANK;
    dlo_d  = DIG_BLANK;
    case (state_d)
      SSC_RUN:
      begin
        pair_d = PAIR_ON;
        run_d  = 1'b1;
        stop_d = 1'b0;
        dhi_d  = zone_digit(zone_set_in);
        dlo_d  = scan_digit(scans);
      end
      SSC_ILK:
      begin
        ilk_d = 1'b1;
        dhi_d = DIG_ILK_HI;
        dlo_d = DIG_ILK_LO;
      end
      SSC_FAULT:
      begin
        ilk_d = flash_q;
        dhi_d = DIG_FAULT_HI;
        dlo_d = fault_code_in;
      end
      default:
        pair_d = PAIR_OFF;
    endcase
    if (aux_mode_in == SSC_AUX_ALARM)
      aux_d = (state_d == SSC_FAULT);
    else
      aux_d = (pair_d == PAIR_ON);
  end

  // Registers only; every pin comes straight from one of these.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      fcnt_q  <= 4'h0;
      flash_q <= 1'b0;
      warn_q  <= 1'b0;
      pair_q  <= PAIR_OFF;
      run_q   <= 1'b0;
      stop_q  <= 1'b1;
      ilk_q   <= 1'b0;
      aux_q   <= 1'b0;
      dhi_q   <= DIG_BLANK;
      dlo_q   <= DIG_BLANK;
    end
    else
    begin
      fcnt_q  <= fcnt_d;
      flash_q <= flash_d;
      warn_q  <= warn_d;
      pair_q  <= pair_d;
      run_q   <= run_d;
      stop_q  <= stop_d;
      ilk_q   <= ilk_d;
      aux_q   <= aux_d;
      dhi_q   <= dhi_d;
      dlo_q   <= dlo_d;
    end
  end

  assign safety_output_pair_out = pair_q;
  assign run_led_out            = run_q;
  assign stop_led_out           = stop_q;
  assign ilk_led_out            = ilk_q;
  assign aux_out                = aux_q;
  assign warn_out               = warn_q;
  assign diag_hi_out            = dhi_q;
  assign diag_lo_out            = dlo_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  run_outputs_a: assert property (state_q == SSC_RUN |->
    pair_q == PAIR_ON && run_q && !stop_q)
    else $error("run state without outputs on");
  stop_outputs_a: assert property (state_q == SSC_STOP |->
    pair_q == PAIR_OFF && stop_q && !run_q && !ilk_q)
    else $error("stop state indication wrong");
  ilk_outputs_a: assert property (state_q == SSC_ILK |->
    pair_q == PAIR_OFF && stop_q && ilk_q && dhi_q == 4'h0 && dlo_q == 4'h1)
    else $error("interlock indication wrong");
  fault_outputs_a: assert property (state_q == SSC_FAULT |->
    pair_q == PAIR_OFF && stop_q && dhi_q == 4'h5)
    else $error("fault indication wrong");
  fault_aux_a: assert property (state_q == SSC_FAULT && $stable(aux_mode_in) |->
    aux_q == (aux_mode_in == SSC_AUX_ALARM))
    else $error("auxiliary output wrong in fault");
  fault_hold_a: assert property (state_q == SSC_FAULT && selftest_fail_in |=>
    state_q == SSC_FAULT)
    else $error("fault left while still failing");
  run_code_a: assert property (state_q == SSC_RUN |->
    dhi_q != 4'h5 && !(dhi_q == 4'h0 && dlo_q == 4'h1))
    else $error("run shows interlock or fault code");
  auto_run_a: assert property (state_q == SSC_STOP && start_mode_in == SSC_AUTO
    && !safety_zone_in && !selftest_fail_in |=> state_q == SSC_RUN)
    else $error("auto mode did not resume run");
  init_off_a: assert property (state_q == SSC_INIT |-> pair_q == PAIR_OFF)
    else $error("outputs on during initialization");
  start_run_a: assert property (state_q == SSC_ILK && lnk.start_pulse
    && !safety_zone_in && !selftest_fail_in |=> state_q == SSC_RUN)
    else $error("start did not leave interlock");
  restart_ilk_a: assert property (state_q == SSC_STOP
    && start_mode_in == SSC_RESTART_ILK && !safety_zone_in
    && !selftest_fail_in |=> state_q == SSC_ILK)
    else $error("restart mode did not interlock");
  resp_stop_a: assert property (state_q == SSC_RUN && safety_zone_in
    && !selftest_fail_in && !lnk.expired |=> state_q == SSC_RUN)
    else $error("run left before response time");
  warn_follow_a: assert property (##1 warn_q == $past(warn_zone_in))
    else $error("warning output not following zone");

  run_seen_c: cover property (state_q == SSC_RUN ##1 state_q == SSC_STOP);
  ilk_start_c: cover property (state_q == SSC_ILK ##1 state_q == SSC_RUN);
  fault_exit_c: cover property (state_q == SSC_FAULT ##1 state_q == SSC_INIT);
endmodule
`default_nettype wire

// >>> tb/ssc_operator_model.sv
// Model of the far side: the operator at the start button and the guarded
// machine, which only moves while both safety outputs are on.
// Assumes the bench raises press_req_in for one cycle while busy_out is low.
`timescale 1ns/1ns
`default_nettype none
module ssc_operator_model (
  input  wire logic       clk_in,
  input  wire logic       press_req_in,
  input  wire logic [7:0] hold_cyc_in,
  input  wire logic [1:0] pair_in,
  output logic            start_btn_out,
  output logic            busy_out,
  output logic            machine_run_out
);
  logic [7:0] left_q = 8'h00;
  logic       btn_q  = 1'b0;
  logic       busy_q = 1'b0;

  // Each output has one driver; the start values stand in for a reset.
  assign start_btn_out = btn_q;
  assign busy_out      = busy_q;

  // ==========================================================
  // Button sequence
  // full press release
  // The button is always released after the hold, so a stuck press is never shown.
  always @(negedge clk_in)
  begin
    if (!busy_q && press_req_in)
    begin
      btn_q  <= 1'b1;
      busy_q <= 1'b1;
      left_q <= hold_cyc_in;
    end
    else if (busy_q && left_q != 8'h00)
      left_q <= left_q - 8'h01;
    else if (busy_q && btn_q)
      btn_q <= 1'b0; // Release, then one idle cycle before busy drops.
    else
      busy_q <= 1'b0;
  end

  // The machine is allowed to move only with both outputs on.
  assign machine_run_out = (pair_in == 2'h3);
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the safeguard state controller.
// Assumes a short scan period so response and flash timing stay brief.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ssc_pkg::*;
  localparam int SCAN_SIM = 10;
  // Packed view {0,0,pair,run,stop,ilk,aux}.
  localparam logic [7:0] RUN_F = 8'h39;
  localparam logic [7:0] RUN_A = 8'h38;
  localparam logic [7:0] STOP  = 8'h04;
  localparam logic [7:0] ILK   = 8'h06;

  logic       clk = 1'b0, nrst = 1'b0, zone = 1'b0, warn = 1'b0, done = 1'b0, fail = 1'b0;
  logic [3:0] fcode = 4'h3;
  ssc_mode_t  mode = SSC_AUTO;
  ssc_aux_t   auxm = SSC_AUX_FOLLOW;
  logic [4:0] scans = 5'h02;
  logic [1:0] zset = 2'h2;
  logic [1:0] pair;
  logic       run, stop, ilk, auxo, warno, btn, busy, mach;
  logic       press_req = 1'b0;
  logic [7:0] hold = 8'h01;
  logic [3:0] dhi, dlo;
  logic [7:0] st_v;
  logic       ilk_s;
  int         errors = 0;
  int         cmp_count = 0;
  logic [4:0] sc_tab [4] = '{5'h02, 5'h09, 5'h0a, 5'h11};
  logic [3:0] lo_tab [4] = '{4'h2, 4'h9, 4'h0, 4'h0};

  assign st_v = {2'h0, pair, run, stop, ilk, auxo};

  always #4 clk = ~clk;

  ssc_ctrl #(.SCAN_CYC(SCAN_SIM)) uut (
    .clk_in(clk), .nrst_in(nrst), .safety_zone_in(zone), .warn_zone_in(warn),
    .selftest_done_in(done), .selftest_fail_in(fail), .fault_code_in(fcode),
    .start_btn_in(btn), .start_mode_in(mode), .aux_mode_in(auxm),
    .scan_count_in(scans), .zone_set_in(zset), .safety_output_pair_out(pair),
    .run_led_out(run), .stop_led_out(stop), .ilk_led_out(ilk), .aux_out(auxo),
    .warn_out(warno), .diag_hi_out(dhi), .diag_lo_out(dlo));

  ssc_operator_model op (
    .clk_in(clk), .press_req_in(press_req), .hold_cyc_in(hold), .pair_in(pair),
    .start_btn_out(btn), .busy_out(busy), .machine_run_out(mach));

  // ==========================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reset with the self-tests pending, then let them finish.
  task automatic do_reset(input ssc_mode_t m, input logic z);
    @(negedge clk);
    nrst = 1'b0;
    done = 1'b0;
    mode = m;
    zone = z;
    cyc(20);
    chk(st_v, STOP);
    nrst = 1'b1;
    cyc(5);
    chk({6'h0, pair}, 8'h00);
    done = 1'b1;
    cyc(4);
  endtask

  // Start one operator press held for h+1 cycles; returns once the model is busy.
  // The extra cycle matters: busy is only seen high one edge after the request.
  task automatic press_go(input logic [7:0] h);
    hold <= h;
    press_req <= 1'b1;
    cyc(1);
    press_req <= 1'b0;
    cyc(1);
  endtask

  // Wait out the running press under a bound; a press that never ends is a mismatch.
  task automatic press_wait;
    int k;
    for (k = 0; k < 400 && (busy || btn); k++)
      cyc(1);
    chk({6'h0, busy, btn}, 8'h00);
    cyc(4);
  endtask

  // One complete operator press held for h+1 cycles.
  task automatic press(input logic [7:0] h);
    press_go(h);
    press_wait();
  endtask

  // Intrusion in run: no stop before the response time, stop after it.
  task automatic intrude;
    zone = 1'b1;
    cyc(15);
    chk({7'h0, mach}, 8'h01);
    cyc(10);
    chk(st_v, STOP);
    chk({dhi, dlo}, 8'hff);
  endtask

  task automatic complete_run;
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // Watchdog, sized well above the few hundred cycles the tests take.
  initial
  begin
    #(8 * 20000);
    errors++;
    complete_run();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    do_reset(SSC_AUTO, 1'b0);
    chk(st_v, RUN_F);
    press(8'h02);
    chk(st_v, RUN_F);
    warn = 1'b1;
    cyc(3);
    chk({warno, st_v[6:0]}, RUN_F | 8'h80);
    warn = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      scans = sc_tab[i];
      zset = 2'(i % 3 + 1);
      cyc(3);
      chk({dhi, dlo}, {(i % 3 == 2) ? DIG_UNION : 4'(i % 3 + 1), lo_tab[i]});
    end
    // Scans below the range clamp to two; zone setting zero shows a blank digit.
    scans = 5'h00;
    zset = 2'h0;
    cyc(3);
    chk({dhi, dlo}, 8'hf2);
    scans = 5'h02;
    intrude();
    zone = 1'b0;
    cyc(3);
    chk(st_v, RUN_F);
    auxm = SSC_AUX_ALARM;
    cyc(3);
    chk(st_v, RUN_A);
    fail = 1'b1;
    cyc(3);
    chk(st_v & 8'hfd, 8'h05);
    chk({dhi, dlo}, 8'h53);
    ilk_s = ilk;
    cyc(50);
    chk({7'h0, ilk}, {7'h0, ~ilk_s});
    press(8'h01);
    auxm = SSC_AUX_FOLLOW;
    cyc(3);
    chk(st_v & 8'hfd, 8'h04);
    fail = 1'b0;
    cyc(5);
    chk(st_v, RUN_F);
    // Start interlock mode, powered up with the zone obstructed.
    do_reset(SSC_START_ILK, 1'b1);
    chk(st_v, STOP);
    zone = 1'b0;
    cyc(3);
    chk(st_v, ILK);
    chk({dhi, dlo}, 8'h01);
    // A button held down with the zone clear must not start until released.
    press_go(8'h28);
    cyc(20);
    chk(st_v, ILK);
    press_wait();
    chk(st_v, RUN_F);
    intrude();
    zone = 1'b0;
    cyc(3);
    chk(st_v, RUN_F);
    // Start/restart interlock mode, powered up with the zone obstructed.
    do_reset(SSC_RESTART_ILK, 1'b1);
    chk(st_v, STOP);
    zone = 1'b0;
    cyc(3);
    chk(st_v, ILK);
    btn_held_check();
    press(8'h01);
    chk(st_v, RUN_F);
    intrude();
    zone = 1'b0;
    cyc(3);
    chk(st_v, ILK);
    press(8'h03);
    chk(st_v, RUN_F);
    complete_run();
  end

  // A press while the zone is obstructed is consumed and never starts.
  task automatic btn_held_check;
    zone = 1'b1;
    press(8'h02);
    cyc(3);
    zone = 1'b0;
    cyc(3);
    chk(st_v, ILK);
  endtask
endmodule
`default_nettype wire
